/* File: design/dic_top.sv */
// module: eight-channel digital input conditioner with a Wishbone register slave
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dic_top
  import dic_pkg::*;
#(
  parameter int MS_CYCLES = DIC_MS_CYCLES
)
(
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [DIC_ADR_W-1:0]          wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // measured voltages, channel n in bits n*19 upward, millivolts
  input  wire logic [DIC_NCH*DIC_VOLT_W-1:0] volt_i,
  // conditioned results
  output logic      [DIC_NCH-1:0]            status_o,
  output logic                               irq_o
);

  // ----------------------------------------------------------------
  // timebase: millisecond tick and scan tick
  // ----------------------------------------------------------------
  logic [31:0] ms_cnt_reg, ms_cnt_next;
  logic [2:0]  scan_cnt_reg, scan_cnt_next;
  logic        ms_tick_reg, ms_tick_next;
  logic        scan_tick_reg, scan_tick_next;

  always_comb
  begin
    ms_cnt_next    = ms_cnt_reg + 32'h00000001;
    scan_cnt_next  = scan_cnt_reg;
    ms_tick_next   = 1'b0;
    scan_tick_next = 1'b0;
    if (ms_cnt_reg == 32'(MS_CYCLES - 1))
    begin
      ms_cnt_next  = '0;
      ms_tick_next = 1'b1;
      if (scan_cnt_reg == DIC_SCAN_LAST)
      begin
        scan_cnt_next  = '0;
        scan_tick_next = 1'b1;
      end
      else
        scan_cnt_next = scan_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ms_cnt_reg    <= '0;
      scan_cnt_reg  <= '0;
      ms_tick_reg   <= 1'b0;
      scan_tick_reg <= 1'b0;
    end
    else
    begin
      ms_cnt_reg    <= ms_cnt_next;
      scan_cnt_reg  <= scan_cnt_next;
      ms_tick_reg   <= ms_tick_next;
      scan_tick_reg <= scan_tick_next;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [1:0]           cfg_reg     [DIC_NCH], cfg_next     [DIC_NCH];
  logic [DIC_THR_W-1:0] act_thr_reg [DIC_NCH], act_thr_next [DIC_NCH];
  logic [DIC_THR_W-1:0] rel_thr_reg [DIC_NCH], rel_thr_next [DIC_NCH];
  logic [DIC_DLY_W-1:0] act_dly_reg [DIC_NCH], act_dly_next [DIC_NCH];
  logic [DIC_DLY_W-1:0] drop_dly_reg[DIC_NCH], drop_dly_next[DIC_NCH];
  logic [DIC_NCH-1:0]   clr_reg, clr_next;
  logic [DIC_NCH-1:0]   irq_stat_reg, irq_stat_next;
  logic [DIC_NCH-1:0]   irq_mask_reg, irq_mask_next;
  logic [DIC_NCH-1:0]   status_reg, status_next;
  logic                 irq_reg, irq_next;
  logic                 ack_reg, ack_next;
  logic [31:0]          dat_reg, dat_next;

  logic [DIC_NCH-1:0]   ch_status;
  logic [DIC_NCH-1:0]   ch_rise;
  logic [DIC_CNT_W-1:0] ch_count [DIC_NCH];
  logic [DIC_VOLT_W-1:0] ch_volt [DIC_NCH];

  logic                 req;
  logic                 wr;
  logic                 chan_hit;
  logic [2:0]           ch_idx;
  logic [2:0]           ch_ofs;
  logic [31:0]          wmask;
  logic [31:0]          cur;

  // byte lanes of the write become a bit mask applied to each register
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmask[b*8 +: 8] = wb_sel_i[b] ? 8'hff : 8'h00;
  end

  always_comb
  begin
    req      = wb_cyc_i && wb_stb_i && !ack_reg;
    wr       = req && wb_we_i;
    chan_hit = wb_adr_i[DIC_ADR_W-1:8] == DIC_CHAN_BASE[DIC_ADR_W-1:8];
    ch_idx   = wb_adr_i[7:5];
    ch_ofs   = wb_adr_i[4:2];
    ack_next = req;
    dat_next = dat_reg;
    cur      = '0;
    clr_next = '0;
    irq_mask_next = irq_mask_reg;
    // hardware set wins over a write-one clear in the same cycle
    irq_stat_next = irq_stat_reg | ch_rise;
    for (int c = 0; c < DIC_NCH; c++)
    begin
      cfg_next[c]      = cfg_reg[c];
      act_thr_next[c]  = act_thr_reg[c];
      rel_thr_next[c]  = rel_thr_reg[c];
      act_dly_next[c]  = act_dly_reg[c];
      drop_dly_next[c] = drop_dly_reg[c];
    end
    if (req && !chan_hit)
    begin
      case (wb_adr_i)
        DIC_STATUS_OFS:   cur = {24'h000000, status_reg};
        DIC_IRQ_STAT_OFS: cur = {24'h000000, irq_stat_reg};
        DIC_IRQ_MASK_OFS: cur = {24'h000000, irq_mask_reg};
        default:          cur = '0;
      endcase
      if (wr && wb_adr_i == DIC_IRQ_STAT_OFS)
        irq_stat_next = (irq_stat_reg & ~(wb_dat_i[DIC_NCH-1:0] & wmask[DIC_NCH-1:0])) | ch_rise;
      if (wr && wb_adr_i == DIC_IRQ_MASK_OFS)
        irq_mask_next = (irq_mask_reg & ~wmask[DIC_NCH-1:0]) | (wb_dat_i[DIC_NCH-1:0] & wmask[DIC_NCH-1:0]);
    end
    else if (req && wb_adr_i[1:0] == 2'h0)
    begin
      // per-channel settings
      case (ch_ofs)
        DIC_CH_CFG:      cur = {30'h00000000, cfg_reg[ch_idx]};
        DIC_CH_ACT_THR:  cur = {16'h0000, act_thr_reg[ch_idx]};
        DIC_CH_REL_THR:  cur = {16'h0000, rel_thr_reg[ch_idx]};
        DIC_CH_ACT_DLY:  cur = {11'h000, act_dly_reg[ch_idx]};
        DIC_CH_DROP_DLY: cur = {11'h000, drop_dly_reg[ch_idx]};
        DIC_CH_COUNT:    cur = ch_count[ch_idx];
        DIC_CH_VOLT:     cur = {13'h0000, ch_volt[ch_idx]};
        default:         cur = '0;
      endcase
      if (wr)
      begin
        case (ch_ofs)
          DIC_CH_CFG:      cfg_next[ch_idx]      = 2'((cur & ~wmask) | (wb_dat_i & wmask));
          DIC_CH_ACT_THR:  act_thr_next[ch_idx]  = 16'((cur & ~wmask) | (wb_dat_i & wmask));
          DIC_CH_REL_THR:  rel_thr_next[ch_idx]  = 16'((cur & ~wmask) | (wb_dat_i & wmask));
          DIC_CH_ACT_DLY:  act_dly_next[ch_idx]  = 21'((cur & ~wmask) | (wb_dat_i & wmask));
          DIC_CH_DROP_DLY: drop_dly_next[ch_idx] = 21'((cur & ~wmask) | (wb_dat_i & wmask));
          DIC_CH_CLEAR:    clr_next[ch_idx]      = wb_dat_i[DIC_CLR_BIT] && wb_sel_i[0];
          default:         clr_next = '0;
        endcase
      end
    end
    if (req && !wb_we_i)
      dat_next = cur;
    status_next = ch_status;
    irq_next    = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < DIC_NCH; c++)
      begin
        cfg_reg[c]      <= 2'h0;                      // normally open, ac off
        act_thr_reg[c]  <= DIC_ACT_THR_RST;
        rel_thr_reg[c]  <= DIC_REL_THR_RST;
        act_dly_reg[c]  <= DIC_DLY_RST;
        drop_dly_reg[c] <= DIC_DLY_RST;
      end
      clr_reg      <= '0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      status_reg   <= '0;
      irq_reg      <= 1'b0;
      ack_reg      <= 1'b0;
      dat_reg      <= '0;
    end
    else
    begin
      for (int c = 0; c < DIC_NCH; c++)
      begin
        cfg_reg[c]      <= cfg_next[c];
        act_thr_reg[c]  <= act_thr_next[c];
        rel_thr_reg[c]  <= rel_thr_next[c];
        act_dly_reg[c]  <= act_dly_next[c];
        drop_dly_reg[c] <= drop_dly_next[c];
      end
      clr_reg      <= clr_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      status_reg   <= status_next;
      irq_reg      <= irq_next;
      ack_reg      <= ack_next;
      dat_reg      <= dat_next;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < DIC_NCH; g++)
  begin : g_ch
    dic_channel u_ch (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .scan_tick_i (scan_tick_reg),
      .ms_tick_i   (ms_tick_reg),
      .volt_i      (volt_i[g*DIC_VOLT_W +: DIC_VOLT_W]),
      .nc_i        (cfg_reg[g][DIC_CFG_NC_BIT]),
      .ac_i        (cfg_reg[g][DIC_CFG_AC_BIT]),
      .act_thr_i   (act_thr_reg[g]),
      .rel_thr_i   (rel_thr_reg[g]),
      .act_dly_i   (act_dly_reg[g]),
      .drop_dly_i  (drop_dly_reg[g]),
      .clr_i       (clr_reg[g]),
      .status_o    (ch_status[g]),
      .rise_o      (ch_rise[g]),
      .count_o     (ch_count[g]),
      .volt_o      (ch_volt[g])
    );
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign status_o = status_reg;
  assign irq_o    = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  scan_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    scan_tick_reg |-> scan_cnt_reg == '0 && $past(ms_tick_next, 1))
    else $error("scan tick off its period");
  // scans fall on millisecond boundaries so delay timers and scans stay in step
  tick_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
    scan_tick_reg |-> ms_tick_reg)
    else $error("scan tick without millisecond tick");
  status_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    status_o == $past(ch_status, 1))
    else $error("status output does not follow channels");
  clear_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && chan_hit && wb_adr_i[1:0] == 2'h0 && ch_ofs == DIC_CH_CLEAR && wb_dat_i[DIC_CLR_BIT] && wb_sel_i[0]
    |=> clr_reg[$past(ch_idx, 1)] ##1 !clr_reg[$past(ch_idx, 2)])
    else $error("clear command not issued once");

  // ----------------------------------------------------------------
  // bus and interrupt checks
  // ----------------------------------------------------------------
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == DIC_IRQ_MASK_OFS && wb_sel_i[0] |=> irq_mask_reg == $past(wb_dat_i[DIC_NCH-1:0], 1))
    else $error("mask write lost");
  // a rise in the cycle of a write-one clear must survive the clear
  irq_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|ch_rise) |=> (irq_stat_reg & $past(ch_rise, 1)) == $past(ch_rise, 1))
    else $error("rise did not set its status bit");
  w1c_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == DIC_IRQ_STAT_OFS && wb_sel_i[0]
    |=> (irq_stat_reg & $past(wb_dat_i[DIC_NCH-1:0] & ~ch_rise, 1)) == '0)
    else $error("status bit not cleared by writing one");
  // the level must match the sticky and mask registers in every cycle
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(irq_stat_reg & irq_mask_reg))
    else $error("interrupt level wrong");

endmodule : dic_top
`default_nettype wire

/* File: design/dic_pkg.sv */
// package: constants of the eight-channel digital input conditioner
package dic_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int          DIC_NCH      = 8;
  localparam int          DIC_VOLT_W   = 19;   // millivolts, 0..275000
  localparam int          DIC_THR_W    = 16;   // 0.1 V steps
  localparam int          DIC_DLY_W    = 21;   // milliseconds
  localparam int          DIC_TMR_W    = 22;
  localparam int          DIC_CNT_W    = 32;
  localparam int          DIC_ADR_W    = 12;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          DIC_CLK_HZ       = 50_000_000;
  localparam int          DIC_MS_PER_S     = 1000;
  localparam int          DIC_MS_CYCLES    = DIC_CLK_HZ / DIC_MS_PER_S;
  localparam int          DIC_SCAN_MS      = 5;
  localparam logic [2:0]  DIC_SCAN_LAST    = 3'(DIC_SCAN_MS - 1);
  localparam logic [DIC_TMR_W-1:0] DIC_AC_EXTRA_MS = 22'h00001e;

  // ----------------------------------------------------------------
  // threshold scaling to millivolts
  // ----------------------------------------------------------------
  localparam logic [23:0] DIC_MV_PER_STEP    = 24'h000064; // 0.1 V step
  localparam logic [23:0] DIC_AC_MV_PER_STEP = 24'h00000a; // ten percent

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DIC_THR_W-1:0] DIC_ACT_THR_RST = 16'h0370; // 88.0 V
  localparam logic [DIC_THR_W-1:0] DIC_REL_THR_RST = 16'h0258; // 60.0 V
  localparam logic [DIC_DLY_W-1:0] DIC_DLY_RST     = 21'h000000;

  // ----------------------------------------------------------------
  // register map: globals, then one 32-byte window per channel
  // ----------------------------------------------------------------
  localparam logic [DIC_ADR_W-1:0] DIC_STATUS_OFS   = 12'h000;
  localparam logic [DIC_ADR_W-1:0] DIC_IRQ_STAT_OFS = 12'h004;
  localparam logic [DIC_ADR_W-1:0] DIC_IRQ_MASK_OFS = 12'h008;
  localparam logic [DIC_ADR_W-1:0] DIC_CHAN_BASE    = 12'h100;
  localparam logic [2:0]  DIC_CH_CFG      = 3'h0;
  localparam logic [2:0]  DIC_CH_ACT_THR  = 3'h1;
  localparam logic [2:0]  DIC_CH_REL_THR  = 3'h2;
  localparam logic [2:0]  DIC_CH_ACT_DLY  = 3'h3;
  localparam logic [2:0]  DIC_CH_DROP_DLY = 3'h4;
  localparam logic [2:0]  DIC_CH_COUNT    = 3'h5;
  localparam logic [2:0]  DIC_CH_CLEAR    = 3'h6;
  localparam logic [2:0]  DIC_CH_VOLT     = 3'h7;
  localparam int          DIC_CFG_NC_BIT  = 0;
  localparam int          DIC_CFG_AC_BIT  = 1;
  localparam int          DIC_CLR_BIT     = 0;

  // ----------------------------------------------------------------
  // channel filter states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DIC_ST_LOW      = 4'b0001,
    DIC_ST_WAIT_ON  = 4'b0010,
    DIC_ST_HIGH     = 4'b0100,
    DIC_ST_WAIT_OFF = 4'b1000
  } dic_state_t;

endpackage : dic_pkg

/* File: design/dic_channel.sv */
// module: one conditioned input channel (hysteresis, polarity, delays, counter)
`timescale 1ns/1ps
`default_nettype none
module dic_channel
  import dic_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // timing ticks
  input  wire logic                 scan_tick_i,
  input  wire logic                 ms_tick_i,
  // measured voltage
  input  wire logic [DIC_VOLT_W-1:0] volt_i,
  // settings
  input  wire logic                 nc_i,
  input  wire logic                 ac_i,
  input  wire logic [DIC_THR_W-1:0] act_thr_i,
  input  wire logic [DIC_THR_W-1:0] rel_thr_i,
  input  wire logic [DIC_DLY_W-1:0] act_dly_i,
  input  wire logic [DIC_DLY_W-1:0] drop_dly_i,
  input  wire logic                 clr_i,
  // results
  output logic                      status_o,
  output logic                      rise_o,
  output logic [DIC_CNT_W-1:0]      count_o,
  output logic [DIC_VOLT_W-1:0]     volt_o
);

  dic_state_t             st_reg, st_next;
  logic [DIC_TMR_W-1:0]   tmr_reg, tmr_next;
  logic                   energ_reg, energ_next;
  logic                   rise_reg, rise_next;
  logic [DIC_CNT_W-1:0]   cnt_reg, cnt_next;
  logic [DIC_VOLT_W-1:0]  volt_reg, volt_next;
  logic [23:0]            act_mv;
  logic [23:0]            rel_mv;
  logic [23:0]            vin;
  logic                   raw;
  logic [DIC_TMR_W-1:0]   off_dly;
  logic [DIC_TMR_W-1:0]   on_dly;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    act_mv     = {8'h00, act_thr_i} * DIC_MV_PER_STEP;
    rel_mv     = ac_i ? {8'h00, act_thr_i} * DIC_AC_MV_PER_STEP
                      : {8'h00, rel_thr_i} * DIC_MV_PER_STEP;
    vin        = {5'h00, volt_i};
    energ_next = energ_reg;
    volt_next  = volt_reg;
    if (scan_tick_i)
    begin
      volt_next = volt_i;
      if (vin > act_mv)
        energ_next = 1'b1;
      else if (vin < rel_mv)
        energ_next = 1'b0;
      // between thresholds the energised level holds
    end
    raw     = energ_next ^ nc_i;
    on_dly  = {1'b0, act_dly_i};
    off_dly = {1'b0, drop_dly_i} + (ac_i ? DIC_AC_EXTRA_MS : '0);
    st_next   = st_reg;
    rise_next = 1'b0;
    tmr_next  = tmr_reg;
    if (ms_tick_i && (st_reg == DIC_ST_WAIT_ON || st_reg == DIC_ST_WAIT_OFF))
      tmr_next = tmr_reg + 22'h000001;
    if (scan_tick_i)
    begin
      case (st_reg)
        DIC_ST_LOW:
        begin
          tmr_next = '0;
          if (raw && on_dly == '0)
          begin
            st_next   = DIC_ST_HIGH;
            rise_next = 1'b1;
          end
          else if (raw)
            st_next = DIC_ST_WAIT_ON;
        end
        DIC_ST_WAIT_ON:
        begin
          if (!raw)
            st_next = DIC_ST_LOW;
          // a millisecond tick landing on this scan already counts
          else if (tmr_next >= on_dly)
          begin
            st_next   = DIC_ST_HIGH;
            rise_next = 1'b1;
          end
        end
        DIC_ST_HIGH:
        begin
          tmr_next = '0;
          if (!raw && off_dly == '0)
            st_next = DIC_ST_LOW;
          else if (!raw)
            st_next = DIC_ST_WAIT_OFF;
        end
        DIC_ST_WAIT_OFF:
        begin
          if (raw)
            st_next = DIC_ST_HIGH;
          else if (tmr_next >= off_dly)
            st_next = DIC_ST_LOW;
        end
        default:
        begin
          st_next  = DIC_ST_LOW;
          tmr_next = '0;
        end
      endcase
    end
    // clear first, then a coincident rise still counts
    cnt_next = clr_i ? '0 : cnt_reg;
    if (rise_next)
      cnt_next = cnt_next + 32'h00000001;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg    <= DIC_ST_LOW;
      tmr_reg   <= '0;
      energ_reg <= 1'b0;
      rise_reg  <= 1'b0;
      cnt_reg   <= '0;
      volt_reg  <= '0;
    end
    else
    begin
      st_reg    <= st_next;
      tmr_reg   <= tmr_next;
      energ_reg <= energ_next;
      rise_reg  <= rise_next;
      cnt_reg   <= cnt_next;
      volt_reg  <= volt_next;
    end
  end

  assign status_o = (st_reg == DIC_ST_HIGH) || (st_reg == DIC_ST_WAIT_OFF);
  assign rise_o   = rise_reg;
  assign count_o  = cnt_reg;
  assign volt_o   = volt_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  count_clear_a: assert property (clr_i && !rise_next |=> cnt_reg == '0)
    else $error("counter not cleared");
  count_step_a: assert property (
    rise_reg |-> cnt_reg == $past(cnt_reg, 1) + 32'h00000001 || $past(clr_i, 1))
    else $error("counter did not step on rise");
  rise_scan_a: assert property (rise_reg |-> $past(scan_tick_i, 1) && status_o)
    else $error("rise outside scan");
  status_scan_a: assert property ($changed(status_o) |-> $past(scan_tick_i, 1))
    else $error("status moved between scans");
  zero_delay_a: assert property (scan_tick_i && st_reg == DIC_ST_LOW && raw && act_dly_i == '0 |=> status_o)
    else $error("zero activation delay not immediate");
  hyst_hold_a: assert property (
    scan_tick_i && vin <= act_mv && vin >= rel_mv |=> energ_reg == $past(energ_reg, 1))
    else $error("state moved inside hysteresis band");
  polarity_a: assert property (scan_tick_i && vin > act_mv |=> (energ_reg ^ nc_i) == !nc_i)
    else $error("polarity applied wrongly");
  volt_read_a: assert property (scan_tick_i |=> volt_o == $past(volt_i, 1))
    else $error("voltage not sampled");
  ac_release_a: assert property (ac_i |-> rel_mv * DIC_AC_MV_PER_STEP == act_mv)
    else $error("ac release threshold not a tenth of activation");

endmodule : dic_channel
`default_nettype wire

/* File: testbench/dic_field.sv */
// field wiring model: holds one measured voltage per input channel
`timescale 1ns/1ps
`default_nettype none
module dic_field
  import dic_pkg::*;
(
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // voltage load request
  input  wire logic                          ld_i,
  input  wire logic [2:0]                    ch_i,
  input  wire logic [DIC_VOLT_W-1:0]         mv_i,
  // voltages seen by the card
  output logic      [DIC_NCH*DIC_VOLT_W-1:0] volt_o
);
  // wiring starts de-energised, each channel keeps its level until reloaded
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      volt_o <= '0;
    else if (ld_i)
      volt_o[ch_i*DIC_VOLT_W +: DIC_VOLT_W] <= mv_i;
  end
endmodule : dic_field
`default_nettype wire

/* File: testbench/tb_dic_top.sv */
// testbench: register and scan-level checks of the input conditioner
`timescale 1ns/1ps
`default_nettype none
module tb_dic_top
  import dic_pkg::*;
;
  localparam int MS = 10;
  localparam int LIMIT = 20000;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ld = 1'b0;
  logic [11:0] adr = '0;
  logic [31:0] dat = '0, wb_dat_o;
  logic [2:0] ch = '0;
  logic [DIC_VOLT_W-1:0] mv = '0;
  logic [DIC_NCH*DIC_VOLT_W-1:0] volt;
  logic [7:0] status_o;
  logic wb_ack_o, irq_o;
  int n_errors = 0, num_checks = 0, cyc_cnt = 0;
  // ----------------------------------------------------------------
  // design and field
  // ----------------------------------------------------------------
  dic_top #(.MS_CYCLES(MS)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .volt_i(volt), .status_o(status_o), .irq_o(irq_o));
  dic_field field_u (.clk_i(clk_i), .rst_i(rst_i), .ld_i(ld), .ch_i(ch), .mv_i(mv), .volt_o(volt));
  always #10 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; the request holds until ack is sampled at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    // no timeout here; only the hang guard ends a wait for an ack that never comes
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, '0, q);
    chk(nm, e, q);
  endtask : rd
  function automatic logic [11:0] ca(input int c, input logic [2:0] r);
    return DIC_CHAN_BASE + 12'(c * 32) + 12'({r, 2'b00});
  endfunction : ca
  task automatic setv(input int c, input int v);
    @(posedge clk_i);
    ld <= 1'b1;
    ch <= 3'(c);
    mv <= DIC_VOLT_W'(v);
    @(posedge clk_i);
    ld <= 1'b0;
  endtask : setv
  task automatic ws(input int n);
    repeat (n * DIC_SCAN_MS * MS) @(posedge clk_i);
  endtask : ws
  task automatic st(input logic [7:0] e);
    rd(DIC_STATUS_OFS, {24'h0, e}, "status reg");
    chk("status_o", {24'h0, e}, {24'h0, status_o});
  endtask : st
  // ----------------------------------------------------------------
  // hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT)
    begin
      n_errors++;
      $display("Error run length expected below %0d seen %0d", LIMIT, cyc_cnt);
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ca(0, DIC_CH_ACT_THR), {16'h0, DIC_ACT_THR_RST}, "act thr");
    rd(ca(0, DIC_CH_REL_THR), {16'h0, DIC_REL_THR_RST}, "rel thr");
    rd(ca(0, DIC_CH_CFG), 32'h0, "cfg");
    rd(ca(0, DIC_CH_ACT_DLY), 32'h0, "act dly");
    rd(ca(0, DIC_CH_DROP_DLY), 32'h0, "drop dly");
    rd(ca(0, DIC_CH_COUNT), 32'h0, "count");
    rd(12'hffc, 32'h0, "unmapped");
    wr(DIC_IRQ_MASK_OFS, 32'h1);
    wr(ca(1, DIC_CH_CFG), 32'h1);
    wr(ca(2, DIC_CH_ACT_THR), 32'd200);
    wr(ca(3, DIC_CH_ACT_DLY), 32'd20);
    wr(ca(4, DIC_CH_CFG), 32'h2);
    setv(0, 100000);
    setv(2, 30000);
    setv(3, 100000);
    setv(4, 100000);
    ws(2);
    st(8'h17);
    rd(ca(0, DIC_CH_COUNT), 32'd1, "count");
    rd(ca(0, DIC_CH_VOLT), 32'd100000, "volt");
    chk("irq_o", 32'h1, {31'h0, irq_o});
    ws(6);
    st(8'h1f);
    wr(DIC_IRQ_STAT_OFS, 32'hff);
    rd(DIC_IRQ_STAT_OFS, 32'h0, "irq stat");
    chk("irq_o", 32'h0, {31'h0, irq_o});
    setv(0, 70000);
    setv(4, 30000);
    ws(2);
    st(8'h1f);
    setv(0, 50000);
    setv(4, 5000);
    ws(2);
    st(8'h1e);
    ws(8);
    st(8'h0e);
    setv(0, 100000);
    ws(2);
    rd(ca(0, DIC_CH_COUNT), 32'd2, "count");
    wr(ca(0, DIC_CH_CLEAR), 32'h1);
    rd(ca(0, DIC_CH_COUNT), 32'd0, "count");
    rd(ca(3, DIC_CH_COUNT), 32'd1, "count");
    wr(ca(3, DIC_CH_DROP_DLY), 32'd20);
    setv(3, 0);
    ws(2);
    st(8'h0f);
    ws(6);
    st(8'h07);
    // normally closed channel driven above its activation threshold goes inactive
    setv(1, 100000);
    ws(2);
    st(8'h05);
    wrap_up();
  end
endmodule : tb_dic_top
`default_nettype wire
